// *** design/dccr_regs.sv ***
// Notes on behaviour
// - Interval-scan bit selects interval acquisition
// - Interval counter clock: pin or sample clock
// - Bit 7 selects EEPROM, pin active low
// - Bit 6 drives shared serial data
// - Bit 5 rising edge shifts data in
// - Bit 5 falling edge shifts EEPROM out
// - Bit 4 high loads selected trim DAC
// - Bit 3 enables dither noise
// - Config bit 7 sets scan direction
// - Bit 6 gates acquisition-done interrupt
// - Bit 5 gates FIFO half-full interrupt
// - Bit 3 sets second DAC range
// - Bit 2 sets first DAC range
// - Bit 1 sets ADC input range
// - Bit 0 picks nonreferenced single-ended mode
// - Calibration register write-only at 1C
// - Config register write-only at 0E
// - Differential bit overrides single-ended modes
// - Status 1D bit 0 shows EEPROM output
// - Half-full status low when half full
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module dccr_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Acquisition circuit status
  input wire logic acq_count_done_in,
  input wire logic half_full_n_in,
  input wire logic nvm_serial_out_in,
  // Clock routing sources
  input wire logic sample_clk_in,
  input wire logic interval_ext_clk_in,
  // Calibration serial lines
  output logic nvm_select_n_out,
  output logic shared_serial_in_out,
  output logic shared_serial_clk_out,
  output logic trim_dac_load_out,
  output logic nvm_write_allow_out,
  // Analog configuration
  output logic dither_on_out,
  output logic scan_ascending_out,
  output logic out1_range_sel_out,
  output logic out0_range_sel_out,
  output logic input_range_sel_out,
  output logic single_ended_ref_sel_out,
  output logic differential_sel_out,
  output dccr_pkg::dccr_in_mode_t input_mode_out,
  // Acquisition mode
  output logic interval_scan_select_out,
  output logic interval_counter_clock_out,
  // Interrupt requests
  output logic acq_done_irq_out,
  output logic half_full_irq_out
);

  dccr_pkg::dccr_state_t state_q;
  dccr_pkg::dccr_state_t state_d;

  logic wr_cal;
  logic wr_cfg;
  logic wr_mode;
  logic rd_status;
  logic interval_scan;
  logic differential;

  assign wr_cal = wr_in && (addr_in == dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR);
  assign wr_cfg = wr_in && (addr_in == dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR);
  assign wr_mode = wr_in && (addr_in == dccr_pkg::ACQ_MODE_CTRL_ADDR);
  assign rd_status = rd_in && (addr_in == dccr_pkg::ACQ_STATUS_ADDR);

  assign interval_scan = state_q.acq_mode[dccr_pkg::INTERVAL_SCAN_SELECT_POS];
  assign differential = state_q.acq_mode[dccr_pkg::DIFFERENTIAL_SEL_POS];

  always_comb
  begin
    state_d = state_q;
    if (wr_cal)
    begin
      state_d.cal = dccr_pkg::dccr_cal_t'(wdata_in);
    end
    if (wr_cfg)
    begin
      state_d.cfg = dccr_pkg::dccr_cfg_t'(wdata_in);
    end
    if (wr_mode)
    begin
      state_d.acq_mode = wdata_in;
    end
    // Write-only registers and unmapped addresses read as zero
    state_d.rdata = dccr_pkg::READ_IDLE_VALUE;
    if (rd_status)
    begin
      state_d.rdata[dccr_pkg::NVM_SERIAL_OUT_POS] = nvm_serial_out_in;
      state_d.rdata[dccr_pkg::ACQ_COUNT_DONE_POS] = acq_count_done_in;
      state_d.rdata[dccr_pkg::HALF_FULL_N_POS] = half_full_n_in;
    end
    state_d.acq_done_irq = state_q.cfg.acq_done_irq_en && acq_count_done_in;
    state_d.half_full_irq = state_q.cfg.half_full_irq_en && !half_full_n_in;
    state_d.icclk = interval_scan ? sample_clk_in : interval_ext_clk_in;
    if (differential)
    begin
      state_d.in_mode = dccr_pkg::DCCR_MODE_DIFF;
    end
    else if (state_q.cfg.single_ended_ref_sel)
    begin
      state_d.in_mode = dccr_pkg::DCCR_MODE_NONREF_SE;
    end
    else
    begin
      state_d.in_mode = dccr_pkg::DCCR_MODE_REF_SE;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state_q.cal <= dccr_pkg::dccr_cal_t'(dccr_pkg::CALIBRATION_SERIAL_CTRL_RST);
      state_q.cfg <= dccr_pkg::dccr_cfg_t'(dccr_pkg::ANALOG_CONFIG_AND_IRQ_RST);
      state_q.acq_mode <= dccr_pkg::ACQ_MODE_CTRL_RST;
      state_q.rdata <= dccr_pkg::READ_IDLE_VALUE;
      state_q.acq_done_irq <= 1'b0;
      state_q.half_full_irq <= 1'b0;
      state_q.icclk <= 1'b0;
      state_q.in_mode <= dccr_pkg::DCCR_MODE_REF_SE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rdata_out = state_q.rdata;

  assign nvm_select_n_out = !state_q.cal.nvm_select;
  assign shared_serial_in_out = state_q.cal.shared_serial_in;
  // Serial clock as written, edges made by software
  assign shared_serial_clk_out = state_q.cal.shared_serial_clk;
  assign trim_dac_load_out = state_q.cal.trim_dac_load;
  assign nvm_write_allow_out = state_q.cal.nvm_write_allow;
  assign dither_on_out = state_q.cal.dither_on;
  assign scan_ascending_out = state_q.cfg.scan_ascending;
  assign out1_range_sel_out = state_q.cfg.out1_range_sel;
  assign out0_range_sel_out = state_q.cfg.out0_range_sel;
  assign input_range_sel_out = state_q.cfg.input_range_sel;
  assign single_ended_ref_sel_out = state_q.cfg.single_ended_ref_sel;
  assign differential_sel_out = differential;
  assign input_mode_out = state_q.in_mode;
  assign interval_scan_select_out = interval_scan;
  assign interval_counter_clock_out = state_q.icclk;
  assign acq_done_irq_out = state_q.acq_done_irq;
  assign half_full_irq_out = state_q.half_full_irq;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // Calibration register write lands on every line
  a_cal_write_lines: assert property (
    wr_cal |=> (nvm_select_n_out == !$past(wdata_in[7]))
      && (shared_serial_in_out == $past(wdata_in[6]))
      && (shared_serial_clk_out == $past(wdata_in[5]))
      && (trim_dac_load_out == $past(wdata_in[4]))
      && (dither_on_out == $past(wdata_in[3]))
      && (nvm_write_allow_out == $past(wdata_in[2])))
    else $error("calibration lines do not follow the write");

  // Serial clock only moves on a calibration write
  a_sclk_edge_cause: assert property (
    !wr_cal |=> $stable(shared_serial_clk_out) && $stable(shared_serial_in_out)
      && $stable(nvm_select_n_out) && $stable(trim_dac_load_out))
    else $error("serial lines moved without a calibration write");

  // Config register write lands on every line
  a_cfg_write_lines: assert property (
    wr_cfg |=> (scan_ascending_out == $past(wdata_in[7]))
      && (out1_range_sel_out == $past(wdata_in[3]))
      && (out0_range_sel_out == $past(wdata_in[2]))
      && (input_range_sel_out == $past(wdata_in[1]))
      && (single_ended_ref_sel_out == $past(wdata_in[0])))
    else $error("config lines do not follow the write");

  // Config lines hold without a write
  a_cfg_hold: assert property (
    !wr_cfg |=> $stable(scan_ascending_out) && $stable(out1_range_sel_out)
      && $stable(out0_range_sel_out) && $stable(input_range_sel_out)
      && $stable(single_ended_ref_sel_out))
    else $error("config lines changed without a write");

  // Status read returns pin levels one cycle later
  a_status_read: assert property (
    rd_status |=> rdata_out == {5'h00, $past(half_full_n_in),
      $past(acq_count_done_in), $past(nvm_serial_out_in)})
    else $error("status read data wrong");

  // Write-only registers read back as zero
  a_wo_read_zero: assert property (
    (rd_in && (addr_in == dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR
      || addr_in == dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR)) |=> rdata_out == 8'h00)
    else $error("write-only register read nonzero");

  // Read data stands only in the cycle after a read
  a_read_idle: assert property (
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data present without a read");

  // Acquisition-done interrupt follows gate one cycle late
  a_acq_irq_gate: assert property (
    ##1 acq_done_irq_out == ($past(acq_count_done_in) && $past(state_q.cfg.acq_done_irq_en)))
    else $error("acquisition-done interrupt wrong");

  // Half-full interrupt on active-low flag
  a_hf_irq_gate: assert property (
    (half_full_n_in && state_q.cfg.half_full_irq_en) |=> !half_full_irq_out)
    else $error("half-full interrupt without half-full flag");

  // Interval counter clock source
  a_icclk_route: assert property (
    ##1 interval_counter_clock_out
      == ($past(interval_scan) ? $past(sample_clk_in) : $past(interval_ext_clk_in)))
    else $error("interval counter clock routed wrong");

  // Input mode decode
  a_input_mode: assert property (
    wr_mode ##1 1'b1 |=> input_mode_out == ($past(differential) ? dccr_pkg::DCCR_MODE_DIFF
      : ($past(single_ended_ref_sel_out) ? dccr_pkg::DCCR_MODE_NONREF_SE
      : dccr_pkg::DCCR_MODE_REF_SE)))
    else $error("input mode decode wrong");

  // Reset drives select, serial clock, trim load, read data and input mode to idle
  a_reset_idle: assert property (disable iff (1'b0)
    srst_in |=> nvm_select_n_out && !shared_serial_clk_out && !trim_dac_load_out
      && (rdata_out == 8'h00) && (input_mode_out == dccr_pkg::DCCR_MODE_REF_SE))
    else $error("outputs not idle after reset");

  // Remaining calibration lines hold without a write
  a_cal_hold: assert property (
    !wr_cal |=> $stable(nvm_write_allow_out) && $stable(dither_on_out))
    else $error("calibration lines changed without a write");

  // Interrupt enables follow a config write
  a_irq_en_write: assert property (
    wr_cfg |=> (state_q.cfg.acq_done_irq_en == $past(wdata_in[6]))
      && (state_q.cfg.half_full_irq_en == $past(wdata_in[5])))
    else $error("interrupt enables do not follow the write");

  // Mode register write lands on its lines
  a_mode_write: assert property (
    wr_mode |=> (interval_scan_select_out == $past(wdata_in[0]))
      && (differential_sel_out == $past(wdata_in[3])))
    else $error("mode lines do not follow the write");

  // Mode lines hold without a write
  a_mode_hold: assert property (
    !wr_mode |=> $stable(interval_scan_select_out) && $stable(differential_sel_out))
    else $error("mode lines changed without a write");

  // Differential selection wins over the reference bit
  a_diff_wins: assert property (
    differential_sel_out |=> input_mode_out == dccr_pkg::DCCR_MODE_DIFF)
    else $error("differential mode not selected");

  // Nonreferenced single-ended mode
  a_nonref_mode: assert property (
    (!differential_sel_out && single_ended_ref_sel_out)
      |=> input_mode_out == dccr_pkg::DCCR_MODE_NONREF_SE)
    else $error("nonreferenced mode not selected");

  // Referenced single-ended mode
  a_ref_mode: assert property (
    (!differential_sel_out && !single_ended_ref_sel_out)
      |=> input_mode_out == dccr_pkg::DCCR_MODE_REF_SE)
    else $error("referenced mode not selected");

  // Half-full interrupt raised while the flag is low
  a_hf_irq_set: assert property (
    (!half_full_n_in && state_q.cfg.half_full_irq_en) |=> half_full_irq_out)
    else $error("half-full interrupt missing");

  // Half-full interrupt silent while disabled
  a_hf_irq_off: assert property (
    !state_q.cfg.half_full_irq_en |=> !half_full_irq_out)
    else $error("half-full interrupt while disabled");

  // Acquisition-done interrupt raised with the flag
  a_acq_irq_set: assert property (
    (acq_count_done_in && state_q.cfg.acq_done_irq_en) |=> acq_done_irq_out)
    else $error("acquisition-done interrupt missing");

  // Acquisition-done interrupt silent while disabled
  a_acq_irq_off: assert property (
    !state_q.cfg.acq_done_irq_en |=> !acq_done_irq_out)
    else $error("acquisition-done interrupt while disabled");

  // Connector pin clocks the counter without interval scan
  a_icclk_ext: assert property (
    !interval_scan_select_out |=> interval_counter_clock_out == $past(interval_ext_clk_in))
    else $error("interval counter not on connector clock");

  // Sample clock drives the counter with interval scan
  a_icclk_scan: assert property (
    interval_scan_select_out |=> interval_counter_clock_out == $past(sample_clk_in))
    else $error("interval counter not on sample clock");

  // Unmapped writes leave every register alone
  a_wr_unmapped: assert property (
    (wr_in && !wr_cal && !wr_cfg && !wr_mode)
      |=> $stable(state_q.cal) && $stable(state_q.cfg) && $stable(state_q.acq_mode))
    else $error("unmapped write changed a register");

  // Reads other than status return zero
  a_rd_other_zero: assert property (
    (rd_in && !rd_status) |=> rdata_out == 8'h00)
    else $error("non-status read returned data");

  // Unused status bits read zero
  a_status_upper: assert property (
    rd_status |=> rdata_out[7:3] == 5'h00)
    else $error("status upper bits nonzero");

  // Serial clock rises only from a calibration write
  a_sclk_rise: assert property (
    $rose(shared_serial_clk_out) |-> $past(wr_cal) && $past(wdata_in[5]))
    else $error("serial clock rose without a write");

  // Serial clock falls only from a calibration write
  a_sclk_fall: assert property (
    $fell(shared_serial_clk_out) |-> $past(wr_cal) && !$past(wdata_in[5]))
    else $error("serial clock fell without a write");

  // Trim DAC load rises only from a calibration write
  a_load_rise: assert property (
    $rose(trim_dac_load_out) |-> $past(wr_cal) && $past(wdata_in[4]))
    else $error("trim load rose without a write");

endmodule

// *** common/dccr_pkg.sv ***
package dccr_pkg;

  // Register map
  localparam logic [4:0] ANALOG_CONFIG_AND_IRQ_ADDR = 5'h0e;
  localparam logic [4:0] ACQ_MODE_CTRL_ADDR = 5'h0f;
  localparam logic [4:0] CALIBRATION_SERIAL_CTRL_ADDR = 5'h1c;
  localparam logic [4:0] ACQ_STATUS_ADDR = 5'h1d;

  // Values after reset
  localparam logic [7:0] ANALOG_CONFIG_AND_IRQ_RST = 8'h00;
  localparam logic [7:0] ACQ_MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] CALIBRATION_SERIAL_CTRL_RST = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // Field positions in acq_mode_ctrl
  localparam int INTERVAL_SCAN_SELECT_POS = 0;
  localparam int DIFFERENTIAL_SEL_POS = 3;

  // Field positions in acq_status
  localparam int NVM_SERIAL_OUT_POS = 0;
  localparam int ACQ_COUNT_DONE_POS = 1;
  localparam int HALF_FULL_N_POS = 2;

  typedef struct packed {
    logic nvm_select;
    logic shared_serial_in;
    logic shared_serial_clk;
    logic trim_dac_load;
    logic dither_on;
    logic nvm_write_allow;
    logic [1:0] spare;
  } dccr_cal_t;

  typedef struct packed {
    logic scan_ascending;
    logic acq_done_irq_en;
    logic half_full_irq_en;
    logic spare;
    logic out1_range_sel;
    logic out0_range_sel;
    logic input_range_sel;
    logic single_ended_ref_sel;
  } dccr_cfg_t;

  typedef enum logic [1:0] {
    DCCR_MODE_REF_SE,
    DCCR_MODE_NONREF_SE,
    DCCR_MODE_DIFF
  } dccr_in_mode_t;

  typedef struct packed {
    dccr_cal_t cal;
    dccr_cfg_t cfg;
    logic [7:0] acq_mode;
    logic [7:0] rdata;
    logic acq_done_irq;
    logic half_full_irq;
    logic icclk;
    dccr_in_mode_t in_mode;
  } dccr_state_t;

endpackage

// *** dv/dccr_cal_model.sv ***
`timescale 1ns/1ps
module dccr_cal_model #(
  parameter logic [7:0] READ_PATTERN = 8'hb4
) (
  // Clock
  input wire logic clk_in,
  // Serial lines from the block
  input wire logic nvm_select_n_in,
  input wire logic shared_serial_in_in,
  input wire logic shared_serial_clk_in,
  input wire logic trim_dac_load_in,
  // Serial answer and trim level
  output logic nvm_serial_out_out,
  output logic [7:0] dac_value_out
);
  logic clk_q, load_q, sel_q;
  logic [7:0] sh_q, pat_q;
  // Deselected pin shows the inverse so a stale level never passes
  assign nvm_serial_out_out = sel_q ? pat_q[7] : ~pat_q[7];
  always_ff @(posedge clk_in)
  begin
    clk_q <= shared_serial_clk_in;
    load_q <= trim_dac_load_in;
    sel_q <= ~nvm_select_n_in;
    if (shared_serial_clk_in && !clk_q)
    begin
      sh_q <= {sh_q[6:0], shared_serial_in_in};
    end
    if (!nvm_select_n_in && !sel_q)
    begin
      pat_q <= READ_PATTERN;
    end
    else if (!shared_serial_clk_in && clk_q && sel_q)
    begin
      pat_q <= {pat_q[6:0], pat_q[7]};
    end
    if (trim_dac_load_in && !load_q)
    begin
      dac_value_out <= sh_q;
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] NVM_WORD = 8'hb4;
  localparam logic [7:0] DAC_WORD = 8'h5c;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0, rd_in = 1'b0, acq_count_done_in = 1'b0, half_full_n_in = 1'b1;
  logic sample_clk_in = 1'b0, interval_ext_clk_in = 1'b0;
  logic nvm_serial_out_in, nvm_select_n_out, shared_serial_in_out, shared_serial_clk_out;
  logic trim_dac_load_out, nvm_write_allow_out, dither_on_out, scan_ascending_out;
  logic out1_range_sel_out, out0_range_sel_out, input_range_sel_out, single_ended_ref_sel_out;
  logic differential_sel_out, interval_scan_select_out, interval_counter_clock_out;
  logic acq_done_irq_out, half_full_irq_out;
  logic [7:0] rdata_out, dac_value;
  dccr_pkg::dccr_in_mode_t input_mode_out;
  int n_fail = 0;
  int n_compared = 0;
  wire [7:0] cal_view = {~nvm_select_n_out, shared_serial_in_out, shared_serial_clk_out,
    trim_dac_load_out, dither_on_out, nvm_write_allow_out, 2'b00};
  wire [7:0] cfg_view = {scan_ascending_out, 3'b000, out1_range_sel_out, out0_range_sel_out,
    input_range_sel_out, single_ended_ref_sel_out};

  dccr_regs u_dccr_regs (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .acq_count_done_in, .half_full_n_in, .nvm_serial_out_in, .sample_clk_in,
    .interval_ext_clk_in, .nvm_select_n_out, .shared_serial_in_out, .shared_serial_clk_out,
    .trim_dac_load_out, .nvm_write_allow_out, .dither_on_out, .scan_ascending_out,
    .out1_range_sel_out, .out0_range_sel_out, .input_range_sel_out, .single_ended_ref_sel_out,
    .differential_sel_out, .input_mode_out, .interval_scan_select_out,
    .interval_counter_clock_out, .acq_done_irq_out, .half_full_irq_out);

  dccr_cal_model #(.READ_PATTERN(NVM_WORD)) u_dccr_cal_model (.clk_in,
    .nvm_select_n_in(nvm_select_n_out), .shared_serial_in_in(shared_serial_in_out),
    .shared_serial_clk_in(shared_serial_clk_out), .trim_dac_load_in(trim_dac_load_out),
    .nvm_serial_out_out(nvm_serial_out_in), .dac_value_out(dac_value));

  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic t_regs();
    logic [7:0] d;
    chk(cal_view | cfg_view, 8'h00);
    // Low two bits written as zero
    for (int i = 2; i < 8; i++)
    begin
      wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, 8'h01 << i);
      chk(cal_view, 8'h01 << i);
    end
    for (int i = 0; i < 8; i++)
    begin
      // Config bit 4 written as zero
      if (i != 4)
      begin
        wr(dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR, 8'h01 << i);
        chk(cfg_view, (8'h01 << i) & 8'h8f);
      end
    end
    chk(cal_view, 8'h80);
    wr(5'h05, 8'hff);
    chk(cal_view | cfg_view, 8'h80);
    rd(5'h05, d);
    chk(d, 8'h00);
    rd(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, d);
    chk(d, 8'h00);
    rd(dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR, d);
    chk(d, 8'h00);
  endtask

  task automatic t_mode();
    logic [1:0] m;
    for (int k = 0; k < 4; k++)
    begin
      m = k[1] ? 2'd2 : (k[0] ? 2'd1 : 2'd0);
      @(posedge clk_in);
      sample_clk_in <= k[1];
      interval_ext_clk_in <= !k[1];
      wr(dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR, {7'h00, k[0]});
      wr(dccr_pkg::ACQ_MODE_CTRL_ADDR, {4'h0, k[1], 2'b00, k[0]});
      cyc(1);
      chk({6'h00, input_mode_out}, {6'h00, m});
      chk({6'h00, differential_sel_out, single_ended_ref_sel_out}, {6'h00, k[1], k[0]});
      chk({6'h00, interval_scan_select_out, interval_counter_clock_out},
        {6'h00, k[0], k[0] ? k[1] : !k[1]});
    end
  endtask

  task automatic t_irq();
    logic [7:0] d;
    wr(dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR, 8'h60);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_in);
      acq_count_done_in <= k[0];
      half_full_n_in <= !k[1];
      cyc(2);
      chk({6'h00, acq_done_irq_out, half_full_irq_out}, {6'h00, k[0], k[1]});
      rd(dccr_pkg::ACQ_STATUS_ADDR, d);
      chk(d & 8'hfe, {5'h00, !k[1], k[0], 1'b0});
    end
    wr(dccr_pkg::ANALOG_CONFIG_AND_IRQ_ADDR, 8'h00);
    cyc(1);
    chk({6'h00, acq_done_irq_out, half_full_irq_out}, 8'h00);
  endtask

  task automatic t_serial();
    logic [7:0] d;
    for (int i = 7; i >= 0; i--)
    begin
      wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, {1'b0, DAC_WORD[i], 6'h00});
      wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, {1'b0, DAC_WORD[i], 6'h20});
    end
    wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, 8'h10);
    cyc(2);
    chk(dac_value, DAC_WORD);
    wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, 8'h80);
    for (int i = 7; i >= 0; i--)
    begin
      rd(dccr_pkg::ACQ_STATUS_ADDR, d);
      chk({7'h00, d[0]}, {7'h00, NVM_WORD[i]});
      wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, 8'ha0);
      wr(dccr_pkg::CALIBRATION_SERIAL_CTRL_ADDR, 8'h80);
    end
  endtask

  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    t_regs();
    t_mode();
    t_irq();
    t_serial();
    close_out();
  end
endmodule
